// *** spss_params.svh ***
`ifndef SPSS_PARAMS_SVH
`define SPSS_PARAMS_SVH
`define SPSS_SCAN_DONE_BIT   8
`define SPSS_PORT_SEL_BIT    0
`define SPSS_SUMMARY_BIT     7
`define SPSS_SCAN_DONE_VALUE 16'h0100
`define SPSS_SETTLE_MIN_US   16'h0001
`define SPSS_SETTLE_MAX_US   16'h8000
`define SPSS_SETTLE_RESET_US 16'h0001
`define SPSS_CLK_MHZ         50
`define SPSS_US_CYCLES       (`SPSS_CLK_MHZ)
`define SPSS_CMD_PORT        3'h1
`define SPSS_CMD_SETTLE      3'h2
`define SPSS_CMD_ENABLE      3'h3
`define SPSS_CMD_PRESET      3'h4
`define SPSS_CMD_CLS         3'h5
`define SPSS_CMD_RST         3'h6
`define SPSS_Q_PORT          3'h1
`define SPSS_Q_SETTLE        3'h2
`define SPSS_Q_SETTLE_MIN    3'h3
`define SPSS_Q_SETTLE_MAX    3'h4
`define SPSS_Q_EVENT         3'h5
`define SPSS_Q_ENABLE        3'h6
`define SPSS_LAST_CHAN       4'hf
`endif

// *** spss_pkg.sv ***
package spss_pkg;
  // Settling sequencer states, one-hot.
  typedef enum logic [2:0]
  {
    SPSS_IDLE   = 3'b001,
    SPSS_SETTLE = 3'b010,
    SPSS_PULSE  = 3'b100
  } spss_state_t;
endpackage

// *** spss_top.sv ***
`timescale 1ns/1ns
`include "spss_params.svh"
module spss_top
  import spss_pkg::*;
#(
  parameter int US_CYCLES = `SPSS_US_CYCLES
)
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        cmd_valid,
  input  wire logic [2:0]  cmd_code,
  input  wire logic [15:0] cmd_data,
  input  wire logic        query_valid,
  input  wire logic [2:0]  query_code,
  output logic [15:0]      query_data,
  output logic             query_done,
  input  wire logic        scan_start,
  input  wire logic [3:0]  scan_last_index,
  input  wire logic        scan_trigger,
  input  wire logic [15:0] closed_channels,
  output logic [15:0]      tree_switch_close,
  output logic             fet_close_pulse,
  output logic [3:0]       scan_index,
  output logic             scan_active,
  output logic             summary_bit,
  output logic             analog_bus_port
);

  // Port selection register; low is none, high is the analog bus.
  logic        port_sel;
  logic        next_port_sel;
  // Settling delay in microseconds, one value for the whole card.
  logic [15:0] settle_us;
  logic [15:0] next_settle_us;
  // Enable mask; only the scan-complete position has any effect.
  logic [15:0] enable_mask;
  logic [15:0] next_enable_mask;
  // Sticky scan-complete event bit.
  logic        scan_done;
  logic        next_scan_done;
  // Query answer registers.
  logic [15:0] next_query_data;
  logic        next_query_done;

  // Next values of the registered data outputs, so that none of them glitches.
  logic [15:0] next_tree_switch_close;
  logic        next_summary_bit;
  logic        next_fet_close_pulse;

  // Decoded one-cycle reset-to-defaults strobe; it also aborts a scan.
  logic cmd_rst;
  assign cmd_rst = cmd_valid && (cmd_code == `SPSS_CMD_RST);

  // Clamp a requested delay into the legal range. A zero request would
  // otherwise wrap the microsecond counter and wait far too long.
  function automatic logic [15:0] clamp_us(input logic [15:0] v);
    if (v < `SPSS_SETTLE_MIN_US)
      return `SPSS_SETTLE_MIN_US;
    else if (v > `SPSS_SETTLE_MAX_US)
      return `SPSS_SETTLE_MAX_US;
    else
      return v;
  endfunction

  // Sequencer state.
  spss_state_t state;
  spss_state_t next_state;
  // Microseconds still to wait in the current settling delay.
  logic [15:0] us_left;
  logic [15:0] next_us_left;
  // Clock cycles within the current microsecond.
  logic [15:0] cyc_cnt;
  logic [15:0] next_cyc_cnt;
  // Next values of the list pointer and the scan-running flag.
  logic [3:0]  next_scan_index;
  logic        next_scan_active;
  // One-cycle strobe when the last list entry has been pulsed.
  logic        scan_finish;
  // Last list index, latched when the scan is armed.
  logic [3:0]  last_index;
  logic [3:0]  next_last_index;

  // Configuration and status next values.
  always_comb
  begin
    next_port_sel    = port_sel;
    next_settle_us   = settle_us;
    next_enable_mask = enable_mask;
    next_scan_done   = scan_done;
    next_query_data  = query_data;
    next_query_done  = 1'b0;
    if (cmd_valid)
    begin
      case (cmd_code)
        // Port select; the host must send it before any channel list.
        `SPSS_CMD_PORT:   next_port_sel = cmd_data[`SPSS_PORT_SEL_BIT];
        // One delay per card; out-of-range requests are pulled into range.
        `SPSS_CMD_SETTLE: next_settle_us = clamp_us(cmd_data);
        // The whole mask is kept for read-back, though only bit 8 acts.
        `SPSS_CMD_ENABLE: next_enable_mask = cmd_data;
        // Preset disables every summary contribution at once.
        `SPSS_CMD_PRESET: next_enable_mask = 16'h0000;
        // Clear status drops the scan-complete event.
        `SPSS_CMD_CLS:    next_scan_done = 1'b0;
        `SPSS_CMD_RST:
        begin
          // Reset-to-defaults restores port none and minimum delay.
          next_port_sel    = 1'b0;
          next_settle_us   = `SPSS_SETTLE_RESET_US;
          next_enable_mask = 16'h0000;
          next_scan_done   = 1'b0;
        end
        // Unused command codes change nothing.
        default: next_port_sel = port_sel;
      endcase
    end
    if (query_valid)
    begin
      // Every query is answered one cycle later, known code or not.
      next_query_done = 1'b1;
      case (query_code)
        // Port answer: one for the analog bus, zero for none.
        `SPSS_Q_PORT:       next_query_data = {15'h0000, port_sel};
        // Delay answers are plain microsecond counts; the host formats them.
        `SPSS_Q_SETTLE:     next_query_data = settle_us;
        // The limits are constants, independent of the current setting.
        `SPSS_Q_SETTLE_MIN: next_query_data = `SPSS_SETTLE_MIN_US;
        `SPSS_Q_SETTLE_MAX: next_query_data = `SPSS_SETTLE_MAX_US;
        `SPSS_Q_EVENT:
        begin
          // Only the scan-complete bit exists; all others read zero.
          next_query_data = scan_done ? `SPSS_SCAN_DONE_VALUE : 16'h0000;
          next_scan_done  = 1'b0;
        end
        // Mask read-back returns all sixteen stored bits.
        `SPSS_Q_ENABLE:     next_query_data = enable_mask;
        // Unknown queries answer zero rather than stale data.
        default:            next_query_data = 16'h0000;
      endcase
    end
    // A finishing scan wins over any clear in the same cycle, so an
    // event is never lost to a read or a clear that races it.
    if (scan_finish)
      next_scan_done = 1'b1;
  end

  // Configuration and status registers; the synchronous reset restores
  // the same settings and event bit as the reset-to-defaults command, and also zeroes the query answer.
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      port_sel    <= 1'b0;
      settle_us   <= `SPSS_SETTLE_RESET_US;
      enable_mask <= 16'h0000;
      scan_done   <= 1'b0;
      query_data  <= 16'h0000;
      query_done  <= 1'b0;
    end
    else
    begin
      port_sel    <= next_port_sel;
      settle_us   <= next_settle_us;
      enable_mask <= next_enable_mask;
      scan_done   <= next_scan_done;
      query_data  <= next_query_data;
      query_done  <= next_query_done;
    end
  end

  // Settling sequencer: a trigger taken in idle during an armed scan starts a delay, then one FET pulse.
  // The pulse also advances the channel pointer, or ends the scan after the last entry. The trigger is only sampled in idle, so a trigger taken while
  // a delay runs is ignored rather than queued.
  always_comb
  begin
    next_state       = state;
    next_us_left     = us_left;
    next_cyc_cnt     = cyc_cnt;
    next_scan_index  = scan_index;
    next_scan_active = scan_active;
    next_last_index  = last_index;
    scan_finish      = 1'b0;
    case (state)
      SPSS_IDLE:
      begin
        // Arming a scan takes priority over a trigger in the same cycle.
        if (scan_start)
        begin
          next_scan_active = 1'b1;
          next_scan_index  = 4'h0;
          next_last_index  = scan_last_index;
        end
        else if (scan_active && scan_trigger)
        begin
          // A trigger loads the delay; the cycle counter starts from zero.
          next_state   = SPSS_SETTLE;
          next_us_left = settle_us;
          next_cyc_cnt = 16'h0000;
        end
      end
      SPSS_SETTLE:
      begin
        // One microsecond has passed when the cycle counter wraps.
        if (cyc_cnt == 16'(US_CYCLES - 1))
        begin
          next_cyc_cnt = 16'h0000;
          // The last microsecond ends the wait; otherwise count it down.
          if (us_left == `SPSS_SETTLE_MIN_US)
            next_state = SPSS_PULSE;
          else
            next_us_left = us_left - 16'h0001;
        end
        else
          next_cyc_cnt = cyc_cnt + 16'h0001;
      end
      SPSS_PULSE:
      begin
        next_state = SPSS_IDLE;
        // The last list entry ends the scan and raises scan-complete.
        if (scan_index == last_index)
        begin
          next_scan_active = 1'b0;
          scan_finish      = 1'b1;
        end
        else
          next_scan_index = scan_index + 4'h1;
      end
      // An illegal state code falls back to idle.
      default: next_state = SPSS_IDLE;
    endcase
    // Reset-to-defaults aborts any running scan. The list pointer is left
    // alone; the next scan start rewinds it.
    if (cmd_rst)
    begin
      next_state       = SPSS_IDLE;
      next_scan_active = 1'b0;
    end
  end

  // Sequencer registers; reset leaves the sequencer idle with no scan armed.
  // The pointer and limit are reset too, so no stale list survives.
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      state       <= SPSS_IDLE;
      us_left     <= `SPSS_SETTLE_RESET_US;
      cyc_cnt     <= 16'h0000;
      scan_index  <= 4'h0;
      scan_active <= 1'b0;
      last_index  <= `SPSS_LAST_CHAN;
    end
    else
    begin
      state       <= next_state;
      us_left     <= next_us_left;
      cyc_cnt     <= next_cyc_cnt;
      scan_index  <= next_scan_index;
      scan_active <= next_scan_active;
      last_index  <= next_last_index;
    end
  end

  // Output next values. Each is worked out from the next register values,
  // so the registered outputs line up with the state that they describe.
  always_comb
  begin
    // The pulse is high for exactly the one cycle spent in the pulse state.
    next_fet_close_pulse = (next_state == SPSS_PULSE);
    // Tree switches follow the closed channels only on the analog bus port;
    // a change of the channel map reaches the switches one cycle later.
    if (next_port_sel)
      next_tree_switch_close = closed_channels;
    else
      next_tree_switch_close = 16'h0000;
    // Summary bit: only the scan-complete mask position counts.
    next_summary_bit = next_scan_done && next_enable_mask[`SPSS_SCAN_DONE_BIT];
  end

  // Output registers. They cost a flip-flop per bit but keep the wide
  // channel map and the status decode free of glitches at the pins.
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      // Reset leaves every switch open and every pulse low.
      fet_close_pulse   <= 1'b0;
      tree_switch_close <= 16'h0000;
      summary_bit       <= 1'b0;
    end
    else
    begin
      fet_close_pulse   <= next_fet_close_pulse;
      tree_switch_close <= next_tree_switch_close;
      summary_bit       <= next_summary_bit;
    end
  end

  // The port flag is itself a register, so it leaves the block directly.
  assign analog_bus_port = port_sel;

endmodule

// *** spss_chk.sv ***
`timescale 1ns/1ns
`include "spss_params.svh"
// Port checker; every property runs on sys_clk and sleeps in reset.
module spss_chk
(
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        query_valid,
  input wire logic [2:0]  query_code,
  input wire logic [15:0] query_data,
  input wire logic        query_done,
  input wire logic [15:0] closed_channels,
  input wire logic [15:0] tree_switch_close,
  input wire logic        fet_close_pulse,
  input wire logic [3:0]  scan_index,
  input wire logic        scan_active,
  input wire logic        analog_bus_port
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // The switches are registered, so they follow the map of one cycle before.
  property p_tree_on;
    analog_bus_port |-> tree_switch_close == $past(closed_channels);
  endproperty
  a_tree_on: assert property (p_tree_on) else $error("tree open");
  property p_tree_off;
    !analog_bus_port |-> tree_switch_close == 16'h0;
  endproperty
  a_tree_off: assert property (p_tree_off) else $error("tree shut");
  property p_port;
    query_valid && query_code == `SPSS_Q_PORT
      |=> query_done && query_data == {15'h0, $past(analog_bus_port)};
  endproperty
  a_port: assert property (p_port) else $error("port answer");
  property p_min;
    query_valid && query_code == `SPSS_Q_SETTLE_MIN |=> query_data == 16'h0001;
  endproperty
  a_min: assert property (p_min) else $error("min answer");
  property p_max;
    query_valid && query_code == `SPSS_Q_SETTLE_MAX |=> query_data == 16'h8000;
  endproperty
  a_max: assert property (p_max) else $error("max answer");
  property p_event;
    query_valid && query_code == `SPSS_Q_EVENT |=> query_data inside {16'h0, 16'h0100};
  endproperty
  a_event: assert property (p_event) else $error("event answer");
  // A pulse is one cycle and the shortest delay keeps the next one away.
  property p_fet;
    fet_close_pulse |=> !fet_close_pulse [*2];
  endproperty
  a_fet: assert property (p_fet) else $error("pulse width");
  property p_idx;
    fet_close_pulse |=> !scan_active || scan_index == $past(scan_index) + 4'h1;
  endproperty
  a_idx: assert property (p_idx) else $error("index step");
endmodule

// *** spss_host.sv ***
`timescale 1ns/1ns
// Host model; it moves its lines only at the falling edge.
module spss_host
(
  input  wire logic   sys_clk,
  output logic        cmd_valid,
  output logic [2:0]  cmd_code,
  output logic [15:0] cmd_data,
  output logic        query_valid,
  output logic [2:0]  query_code
);
  initial {cmd_valid, cmd_code, cmd_data, query_valid, query_code} = '0;
  // One command strobe, seen by exactly one rising edge.
  task automatic cmd(input logic [2:0] c, input logic [15:0] d);
    @(negedge sys_clk);
    {cmd_valid, cmd_code, cmd_data} = {1'b1, c, d};
    @(negedge sys_clk);
    cmd_valid = 1'b0;
  endtask
  // One query strobe; the answer is settled when this returns.
  task automatic ask(input logic [2:0] c);
    @(negedge sys_clk);
    {query_valid, query_code} = {1'b1, c};
    @(negedge sys_clk);
    query_valid = 1'b0;
  endtask
endmodule

// *** scan_port_settle_status_bench.sv ***
`timescale 1ns/1ns
`include "spss_params.svh"
module scan_port_settle_status_bench;
  logic        sys_clk = 0, rstn = 0, scan_start = 0, scan_trigger = 0;
  logic [3:0]  scan_last_index = 4'h0;
  logic [15:0] closed_channels = 16'h0, s;
  wire logic   cmd_valid, query_valid, query_done, fet_close_pulse;
  wire logic   scan_active, summary_bit, analog_bus_port;
  wire logic [2:0]  cmd_code, query_code;
  wire logic [3:0]  scan_index;
  wire logic [15:0] cmd_data, query_data, tree_switch_close;
  int num_errors = 0, check_count = 0, n, seed = 32'hbe774b81;
  spss_host h(.sys_clk, .cmd_valid, .cmd_code, .cmd_data, .query_valid, .query_code);
  localparam int US = 2;
  // Two cycles per microsecond keeps the settle waits short.
  spss_top #(.US_CYCLES(US)) uut(.sys_clk, .rstn, .cmd_valid, .cmd_code, .cmd_data,
    .query_valid, .query_code, .query_data, .query_done, .scan_start, .scan_last_index,
    .scan_trigger, .closed_channels, .tree_switch_close, .fet_close_pulse, .scan_index,
    .scan_active, .summary_bit, .analog_bus_port);
  initial forever #10 sys_clk = ~sys_clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic q(input logic [2:0] c, input logic [15:0] exp);
    h.ask(c);
    check(16'(query_done), 16'h1);
    check(query_data, exp);
  endtask
  // Out-of-range settle values are clamped into 1 to 32768.
  function automatic logic [15:0] clamp(input logic [15:0] d);
    return d == 16'h0 ? 16'h0001 : (d > 16'h8000 ? 16'h8000 : d);
  endfunction
  // The watchdog covers a full scan at the longest delay used here.
  initial
  begin
    #1000000;
    num_errors++;
    wrap_up;
  end
  initial
  begin
    repeat (2) @(negedge sys_clk);
    rstn = 1;
    q(`SPSS_Q_PORT, 16'h0);
    q(`SPSS_Q_SETTLE, 16'h1);
    q(`SPSS_Q_SETTLE_MIN, 16'h1);
    q(`SPSS_Q_SETTLE_MAX, 16'h8000);
    closed_channels = 16'($random(seed));
    @(negedge sys_clk) check(tree_switch_close, 16'h0);
    h.cmd(`SPSS_CMD_PORT, 16'h1);
    check(tree_switch_close, closed_channels);
    check(16'(analog_bus_port), 16'h1);
    q(`SPSS_Q_PORT, 16'h1);
    h.cmd(`SPSS_CMD_CLS, 16'h0);
    q(`SPSS_Q_EVENT, 16'h0);
    foreach (s[k])
    begin
      n = (k < 2) ? (k ? 32'hffff : 0) : $random(seed);
      h.cmd(`SPSS_CMD_SETTLE, n[15:0]);
      q(`SPSS_Q_SETTLE, clamp(n[15:0]));
    end
    s = 16'(($random(seed) & 7) + 1);
    h.cmd(`SPSS_CMD_SETTLE, s);
    scan_last_index = 4'($random(seed));
    scan_start = 1;
    @(negedge sys_clk) scan_start = 0;
    for (int i = 0; i <= scan_last_index; i++)
    begin
      check(16'(scan_index), 16'(i));
      scan_trigger = 1;
      @(negedge sys_clk) scan_trigger = 0;
      n = 0;
      while (fet_close_pulse !== 1'b1 && n < 99)
        @(negedge sys_clk) n++;
      check(16'(n), 16'(s * US));
      // The pointer moves on the edge after the pulse; let it pass first.
      @(negedge sys_clk);
    end
    @(negedge sys_clk) check(16'(scan_active), 16'h0);
    h.cmd(`SPSS_CMD_ENABLE, 16'hfeff);
    check(16'(summary_bit), 16'h0);
    h.cmd(`SPSS_CMD_ENABLE, 16'h0100);
    check(16'(summary_bit), 16'h1);
    h.cmd(`SPSS_CMD_PRESET, 16'h0);
    check(16'(summary_bit), 16'h0);
    q(`SPSS_Q_ENABLE, 16'h0);
    h.cmd(`SPSS_CMD_ENABLE, 16'h0100);
    q(`SPSS_Q_EVENT, `SPSS_SCAN_DONE_VALUE);
    check(16'(summary_bit), 16'h0);
    q(`SPSS_Q_EVENT, 16'h0);
    h.cmd(`SPSS_CMD_RST, 16'h0);
    check(tree_switch_close, 16'h0);
    wrap_up;
  end
endmodule
bind spss_top spss_chk chk(.sys_clk, .rstn, .query_valid, .query_code, .query_data,
  .query_done, .closed_channels, .tree_switch_close, .fet_close_pulse, .scan_index,
  .scan_active, .analog_bus_port);
